/* logic/register_reset_initializer.sv */
// special-function registers with per-cause reset and wake-up initialization
//
// Contract
// - brown-out reset loads the power-on values except power flags bit zero, which it keeps; clear and watchdog share values except flag bits four and three.
// - external clear and watchdog reset form one class, distinct from power-on.
// - any reset zeroes program counter low; wake-up advances it by one.
// - interrupt wake-up with global enable set loads the interrupt vector.
// - flags register 0001 1xxx at power-on; clear/watchdog clears top three.
// - options register all ones on any reset, kept on wake-up.
// - both direction registers all ones on any reset, kept on wake-up; port A direction loads 8'h1f instead, setting only its five implemented bits.
// - program counter high latch cleared on reset, kept on wake-up.
// - interrupt control top seven clear on reset; bit zero kept on clear.
// - wake-up keeps interrupt control but sets the causing flag bits.
// - converter control clears implemented bits; pin config low two clear.
// - working, timer, pointer, port B, result kept across clear and wake.
// - unimplemented bits always read zero.
// - without brown-out detection the power flags read zero, no brown-out.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module register_reset_initializer
    import reg_init_pkg::*;
#(
    parameter bit HAS_BROWN_OUT = 1'b1
) (
    // clock and power-on reset
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    // reset and wake-up causes (one-cycle pulses)
    input  wire logic        brown_out_in,
    input  wire logic        external_clear_reset_in,
    input  wire logic        watchdog_reset_in,
    input  wire logic        wake_watchdog_in,
    input  wire logic        wake_interrupt_in,
    input  wire logic [7:0]  wake_int_flags_in,
    input  wire logic        sleeping_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [9:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // state towards the core
    output logic [7:0]       pc_low_out,
    output logic [7:0]       flags_out,
    output logic             global_interrupt_enable_out
);

    // ------------------------------------------------------------
    // cause decode
    // ------------------------------------------------------------
    logic power_event;
    logic clear_event;
    logic wake_event;
    logic brown_ok;

    assign brown_ok    = HAS_BROWN_OUT && brown_out_in;
    assign power_event = srst_in || brown_ok;
    assign clear_event = external_clear_reset_in || watchdog_reset_in;
    assign wake_event  = wake_watchdog_in || wake_interrupt_in;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       setup_phase;
    logic       write_now;
    logic [7:0] index;
    logic       mapped;
    logic [7:0] wdata;

    assign setup_phase = psel_in && !penable_in;
    assign write_now   = psel_in && penable_in && pwrite_in && mapped;
    assign index       = paddr_in[9:2];
    assign wdata       = pwdata_in[7:0];

    function automatic logic is_mapped(input logic [7:0] idx, input logic has_bor);
        case (idx)
            IDX_TIMER, IDX_PC_LOW, IDX_FLAGS, IDX_POINTER,
            IDX_PORT_A, IDX_PORT_B, IDX_CONV_MAIN, IDX_CONV_RES,
            IDX_PC_HIGH, IDX_INT_CTRL, IDX_WORKING, IDX_CAUSE,
            IDX_OPTIONS, IDX_DIR_A, IDX_DIR_B, IDX_CONV_PINS: is_mapped = 1'b1;
            IDX_PWR_FLAGS: is_mapped = has_bor;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic wr_hit(input logic wr, input logic [7:0] idx,
                                    input logic [7:0] target);
        wr_hit = wr && (idx == target);
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
                                         input logic [7:0] mask);
        merge = (nv & mask) | (old & ~mask);
    endfunction

    assign mapped      = is_mapped(index, HAS_BROWN_OUT);
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]   working;
    logic [7:0]   timer_zero_count;
    logic [7:0]   program_counter_low;
    logic [7:0]   alu_flags_and_bank;
    logic [7:0]   indirect_pointer;
    logic [7:0]   port_a_pins;
    logic [7:0]   port_b_pins;
    logic [7:0]   program_counter_high_latch;
    logic [7:0]   interrupt_control;
    logic [7:0]   conversion_result;
    logic [7:0]   converter_control_main;
    logic [7:0]   prescaler_and_edge_options;
    logic [7:0]   port_a_direction;
    logic [7:0]   port_b_direction;
    logic [7:0]   power_reset_flags;
    logic [7:0]   converter_pin_config;
    reset_cause_t last_cause;

    // values unknown at power-on come up as zero; kept on clear and wake
    always_ff @(posedge clk_sys_in) begin
        if (power_event) begin
            working          <= RST_ZERO;
            timer_zero_count <= RST_ZERO;
            indirect_pointer <= RST_ZERO;
            port_b_pins      <= RST_ZERO;
            conversion_result <= RST_ZERO;
        end else if (!clear_event && !wake_event) begin
            if (wr_hit(write_now, index, IDX_WORKING)) begin
                working <= wdata;
            end
            if (wr_hit(write_now, index, IDX_TIMER)) begin
                timer_zero_count <= wdata;
            end
            if (wr_hit(write_now, index, IDX_POINTER)) begin
                indirect_pointer <= wdata;
            end
            if (wr_hit(write_now, index, IDX_PORT_B)) begin
                port_b_pins <= wdata;
            end
            if (wr_hit(write_now, index, IDX_CONV_RES)) begin
                conversion_result <= wdata;
            end
        end
    end

    // program counter low byte
    always_ff @(posedge clk_sys_in) begin
        if (power_event || clear_event) begin
            program_counter_low <= RST_ZERO;
        end else if (wake_event) begin
            if (wake_interrupt_in && interrupt_control[INT_GLOBAL_EN]) begin
                program_counter_low <= INT_VECTOR;
            end else begin
                program_counter_low <= program_counter_low + 8'h01;
            end
        end else if (wr_hit(write_now, index, IDX_PC_LOW)) begin
            program_counter_low <= wdata;
        end
    end

    // alu flags and bank; timeout and power-down bits are hardware-owned
    always_ff @(posedge clk_sys_in) begin
        if (power_event) begin
            alu_flags_and_bank <= RST_FLAGS_POR;
        end else if (clear_event) begin
            alu_flags_and_bank[7:5] <= 3'h0;
            if (external_clear_reset_in) begin
                if (sleeping_in) begin
                    alu_flags_and_bank[FLAG_TIMEOUT_N] <= 1'b1;
                    alu_flags_and_bank[FLAG_PWRDOWN_N] <= 1'b0;
                end
            end else begin
                alu_flags_and_bank[FLAG_TIMEOUT_N] <= 1'b0;
                alu_flags_and_bank[FLAG_PWRDOWN_N] <= 1'b1;
            end
        end else if (wake_event) begin
            alu_flags_and_bank[FLAG_TIMEOUT_N] <= !wake_watchdog_in;
            alu_flags_and_bank[FLAG_PWRDOWN_N] <= 1'b0;
        end else if (wr_hit(write_now, index, IDX_FLAGS)) begin
            alu_flags_and_bank <= merge(alu_flags_and_bank, wdata, MASK_FLAGS_WR);
        end
    end

    // port a: low four cleared, bit four kept on clear
    always_ff @(posedge clk_sys_in) begin
        if (power_event) begin
            port_a_pins <= RST_ZERO;
        end else if (clear_event) begin
            port_a_pins <= port_a_pins & 8'h10;
        end else if (!wake_event && wr_hit(write_now, index, IDX_PORT_A)) begin
            port_a_pins <= wdata & MASK_PORT_A;
        end
    end

    // program counter high latch
    always_ff @(posedge clk_sys_in) begin
        if (power_event || clear_event) begin
            program_counter_high_latch <= RST_ZERO;
        end else if (!wake_event && wr_hit(write_now, index, IDX_PC_HIGH)) begin
            program_counter_high_latch <= wdata & MASK_PC_HIGH;
        end
    end

    // interrupt control
    always_ff @(posedge clk_sys_in) begin
        if (power_event) begin
            interrupt_control <= RST_ZERO;
        end else if (clear_event) begin
            interrupt_control <= interrupt_control & 8'h01;
        end else if (wake_interrupt_in) begin
            interrupt_control <= interrupt_control | wake_int_flags_in;
        end else if (!wake_event && wr_hit(write_now, index, IDX_INT_CTRL)) begin
            interrupt_control <= wdata;
        end
    end

    // converter control and pin configuration
    always_ff @(posedge clk_sys_in) begin
        if (power_event || clear_event) begin
            converter_control_main <= RST_ZERO;
            converter_pin_config   <= RST_ZERO;
        end else if (!wake_event) begin
            if (wr_hit(write_now, index, IDX_CONV_MAIN)) begin
                converter_control_main <= wdata & MASK_CONV_MAIN;
            end
            if (wr_hit(write_now, index, IDX_CONV_PINS)) begin
                converter_pin_config <= wdata & MASK_CONV_PINS;
            end
        end
    end

    // options
    always_ff @(posedge clk_sys_in) begin
        if (power_event || clear_event) begin
            prescaler_and_edge_options <= RST_ONES;
        end else if (!wake_event && wr_hit(write_now, index, IDX_OPTIONS)) begin
            prescaler_and_edge_options <= wdata;
        end
    end

    // pin directions
    always_ff @(posedge clk_sys_in) begin
        if (power_event || clear_event) begin
            port_a_direction <= RST_DIR_A;
            port_b_direction <= RST_ONES;
        end else if (!wake_event) begin
            if (wr_hit(write_now, index, IDX_DIR_A)) begin
                port_a_direction <= wdata & MASK_PORT_A;
            end
            if (wr_hit(write_now, index, IDX_DIR_B)) begin
                port_b_direction <= wdata;
            end
        end
    end

    // power flags: power-on bit cleared by power-on or brown-out
    always_ff @(posedge clk_sys_in) begin
        if (!HAS_BROWN_OUT) begin
            power_reset_flags <= RST_ZERO;
        end else if (srst_in) begin
            power_reset_flags <= RST_ZERO;
        end else if (brown_ok) begin
            power_reset_flags[PWR_POR_N] <= 1'b0;
        end else if (!clear_event && !wake_event
                     && wr_hit(write_now, index, IDX_PWR_FLAGS)) begin
            power_reset_flags <= wdata & MASK_PWR_FLAGS;
        end
    end

    // last cause, for software
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            last_cause <= CAUSE_POWER_ON;
        end else if (brown_ok) begin
            last_cause <= CAUSE_BROWN_OUT;
        end else if (external_clear_reset_in) begin
            last_cause <= CAUSE_EXT_CLEAR;
        end else if (watchdog_reset_in) begin
            last_cause <= CAUSE_WATCHDOG;
        end else if (wake_watchdog_in) begin
            last_cause <= CAUSE_WAKE_WDT;
        end else if (wake_interrupt_in) begin
            last_cause <= CAUSE_WAKE_INT;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] next_read;

    always_comb begin
        case (index)
            IDX_TIMER:     next_read = timer_zero_count;
            IDX_PC_LOW:    next_read = program_counter_low;
            IDX_FLAGS:     next_read = alu_flags_and_bank;
            IDX_POINTER:   next_read = indirect_pointer;
            IDX_PORT_A:    next_read = port_a_pins & MASK_PORT_A;
            IDX_PORT_B:    next_read = port_b_pins;
            IDX_CONV_MAIN: next_read = converter_control_main & MASK_CONV_MAIN;
            IDX_CONV_RES:  next_read = conversion_result;
            IDX_PC_HIGH:   next_read = program_counter_high_latch & MASK_PC_HIGH;
            IDX_INT_CTRL:  next_read = interrupt_control;
            IDX_WORKING:   next_read = working;
            IDX_CAUSE:     next_read = {2'b00, last_cause};
            IDX_OPTIONS:   next_read = prescaler_and_edge_options;
            IDX_DIR_A:     next_read = port_a_direction & MASK_PORT_A;
            IDX_DIR_B:     next_read = port_b_direction;
            IDX_PWR_FLAGS: next_read = power_reset_flags & MASK_PWR_FLAGS;
            IDX_CONV_PINS: next_read = converter_pin_config & MASK_CONV_PINS;
            default:       next_read = RST_ZERO;
        endcase
    end

    // read data is captured in the setup cycle and held through access
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata_out <= mapped ? {24'h00_0000, next_read} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // core-facing outputs
    // ------------------------------------------------------------
    assign pc_low_out                  = program_counter_low;
    assign flags_out                   = alu_flags_and_bank;
    assign global_interrupt_enable_out = interrupt_control[INT_GLOBAL_EN];

endmodule

`default_nettype wire

/* shared/reg_init_pkg.sv */
// register map, reset values and cause codes for the register initializer
package reg_init_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_TIMER      = 8'h01;
    localparam logic [7:0] IDX_PC_LOW     = 8'h02;
    localparam logic [7:0] IDX_FLAGS      = 8'h03;
    localparam logic [7:0] IDX_POINTER    = 8'h04;
    localparam logic [7:0] IDX_PORT_A     = 8'h05;
    localparam logic [7:0] IDX_PORT_B     = 8'h06;
    localparam logic [7:0] IDX_CONV_MAIN  = 8'h08;
    localparam logic [7:0] IDX_CONV_RES   = 8'h09;
    localparam logic [7:0] IDX_PC_HIGH    = 8'h0a;
    localparam logic [7:0] IDX_INT_CTRL   = 8'h0b;
    localparam logic [7:0] IDX_WORKING    = 8'h7e;
    localparam logic [7:0] IDX_CAUSE      = 8'h7f;
    localparam logic [7:0] IDX_OPTIONS    = 8'h81;
    localparam logic [7:0] IDX_DIR_A      = 8'h85;
    localparam logic [7:0] IDX_DIR_B      = 8'h86;
    localparam logic [7:0] IDX_PWR_FLAGS  = 8'h87;
    localparam logic [7:0] IDX_CONV_PINS  = 8'h88;

    // ------------------------------------------------------------
    // implemented-bit masks and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_PORT_A    = 8'h1f;
    localparam logic [7:0] MASK_PC_HIGH   = 8'h1f;
    localparam logic [7:0] MASK_CONV_MAIN = 8'hdf;
    localparam logic [7:0] MASK_CONV_PINS = 8'h03;
    localparam logic [7:0] MASK_PWR_FLAGS = 8'h03;
    localparam logic [7:0] MASK_FLAGS_WR  = 8'he7;
    localparam int         FLAG_TIMEOUT_N = 4;
    localparam int         FLAG_PWRDOWN_N = 3;
    localparam int         PWR_POR_N      = 1;
    localparam int         PWR_BOR_N      = 0;
    localparam int         INT_GLOBAL_EN  = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_FLAGS_POR  = 8'h18;
    localparam logic [7:0] RST_ONES       = 8'hff;
    localparam logic [7:0] RST_DIR_A      = 8'h1f;
    localparam logic [7:0] INT_VECTOR     = 8'h04;

    // ------------------------------------------------------------
    // last reset or wake-up cause
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        CAUSE_POWER_ON  = 6'b000001,
        CAUSE_BROWN_OUT = 6'b000010,
        CAUSE_EXT_CLEAR = 6'b000100,
        CAUSE_WATCHDOG  = 6'b001000,
        CAUSE_WAKE_WDT  = 6'b010000,
        CAUSE_WAKE_INT  = 6'b100000
    } reset_cause_t;

endpackage

/* dv/register_reset_initializer_sva.sv */
// concurrent checks on the ports of the register reset initializer
`timescale 1ns/1ns
`default_nettype none

module register_reset_initializer_sva
    import reg_init_pkg::*;
#(
    parameter bit HAS_BROWN_OUT = 1'b1
) (
    // clock and reset
    input wire logic        clk_sys_in,
    input wire logic        srst_in,
    // causes
    input wire logic        brown_out_in,
    input wire logic        external_clear_reset_in,
    input wire logic        watchdog_reset_in,
    input wire logic        wake_watchdog_in,
    input wire logic        wake_interrupt_in,
    input wire logic [7:0]  wake_int_flags_in,
    input wire logic        sleeping_in,
    // apb
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [9:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // core state
    input wire logic [7:0]  pc_low_out,
    input wire logic [7:0]  flags_out,
    input wire logic        global_interrupt_enable_out
);
    logic bor;
    logic no_rst;
    assign bor    = HAS_BROWN_OUT && brown_out_in;
    assign no_rst = !bor && !external_clear_reset_in && !watchdog_reset_in;

    function automatic logic mapped(input logic [7:0] i);
        return (i inside {IDX_TIMER, IDX_PC_LOW, IDX_FLAGS, IDX_POINTER, IDX_PORT_A,
                IDX_PORT_B, IDX_CONV_MAIN, IDX_CONV_RES, IDX_PC_HIGH, IDX_INT_CTRL,
                IDX_WORKING, IDX_CAUSE, IDX_OPTIONS, IDX_DIR_A, IDX_DIR_B, IDX_CONV_PINS})
            || (HAS_BROWN_OUT && i == IDX_PWR_FLAGS);
    endfunction

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    por_values_a: assert property ($fell(srst_in) |-> pc_low_out == 8'h00 &&
        flags_out == RST_FLAGS_POR && !global_interrupt_enable_out) else $error("power-on state");
    bor_same_a: assert property (bor |=> pc_low_out == 8'h00 &&
        flags_out == RST_FLAGS_POR && !global_interrupt_enable_out) else $error("brown-out state");
    clr_keep_a: assert property (external_clear_reset_in && !bor && !sleeping_in |=>
        flags_out[7:5] == 3'b000 && flags_out[4:0] == $past(flags_out[4:0])
        && pc_low_out == 8'h00) else $error("clear state");
    wdt_flags_a: assert property (watchdog_reset_in && !external_clear_reset_in && !bor |=>
        flags_out[7:3] == 5'b00001 && pc_low_out == 8'h00) else $error("watchdog state");
    wake_inc_a: assert property (wake_watchdog_in && !wake_interrupt_in && no_rst |=>
        pc_low_out == $past(pc_low_out) + 8'h01 && flags_out[4:3] == 2'b00)
        else $error("wake increment");
    wake_vec_a: assert property (wake_interrupt_in && global_interrupt_enable_out && no_rst
        |=> pc_low_out == INT_VECTOR && flags_out[4:3] == 2'b10) else $error("wake vector");
    ready_const_a: assert property (pready_out == 1'b1) else $error("ready low");
    err_map_a: assert property (pslverr_out == (psel_in && penable_in
        && !mapped(paddr_in[9:2]))) else $error("slave error");
    rd_unmapped_a: assert property (psel_in && !penable_in && !mapped(paddr_in[9:2]) |=>
        (prdata_out == 32'h0) [*2]) else $error("unmapped read data");
    rd_upper_a: assert property (prdata_out[31:8] == 24'h0) else $error("upper read bits");

    cover property (wake_interrupt_in && global_interrupt_enable_out);
    cover property (psel_in && penable_in && pslverr_out);
    cover property (watchdog_reset_in);
    cover property (bor);
endmodule

bind register_reset_initializer register_reset_initializer_sva #(
    .HAS_BROWN_OUT(HAS_BROWN_OUT)
) i_sva (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .brown_out_in(brown_out_in),
    .external_clear_reset_in(external_clear_reset_in), .watchdog_reset_in(watchdog_reset_in),
    .wake_watchdog_in(wake_watchdog_in), .wake_interrupt_in(wake_interrupt_in),
    .wake_int_flags_in(wake_int_flags_in), .sleeping_in(sleeping_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pc_low_out(pc_low_out), .flags_out(flags_out),
    .global_interrupt_enable_out(global_interrupt_enable_out)
);
`default_nettype wire

/* dv/register_reset_initializer_tb_top.sv */
// self-checking bench for the register reset initializer
`timescale 1ns/1ns
`default_nettype none

module register_reset_initializer_tb_top;
    import reg_init_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed { logic [7:0] idx, por, wr, clr; } row_t;
    logic        clk_sys_in = 1'b0;
    logic        srst_in    = 1'b1;
    logic [4:0]  ev         = 5'h00;
    logic [7:0]  wflags     = 8'h00;
    logic        sleeping   = 1'b0;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [9:0]  paddr_in   = 10'h000;
    logic [31:0] pwdata_in  = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [7:0]  pc_low_out;
    logic [7:0]  flags_out;
    logic        global_interrupt_enable;
    logic [31:0] rd;
    logic        err;
    int          failures     = 0;
    int          total_checks = 0;
    row_t        rows [16] = '{
        '{IDX_TIMER, 8'h00, 8'hff, 8'hff}, '{IDX_PC_LOW, 8'h00, 8'hff, 8'h00},
        '{IDX_FLAGS, 8'h18, 8'hff, 8'h1f}, '{IDX_POINTER, 8'h00, 8'hff, 8'hff},
        '{IDX_PORT_A, 8'h00, 8'h1f, 8'h10}, '{IDX_PORT_B, 8'h00, 8'hff, 8'hff},
        '{IDX_CONV_MAIN, 8'h00, 8'hdf, 8'h00}, '{IDX_CONV_RES, 8'h00, 8'hff, 8'hff},
        '{IDX_PC_HIGH, 8'h00, 8'h1f, 8'h00}, '{IDX_INT_CTRL, 8'h00, 8'hff, 8'h01},
        '{IDX_WORKING, 8'h00, 8'hff, 8'hff}, '{IDX_OPTIONS, 8'hff, 8'hff, 8'hff},
        '{IDX_DIR_A, 8'h1f, 8'h1f, 8'h1f}, '{IDX_DIR_B, 8'hff, 8'hff, 8'hff},
        '{IDX_PWR_FLAGS, 8'h00, 8'h03, 8'h03}, '{IDX_CONV_PINS, 8'h00, 8'h03, 8'h00}};

    always #4 clk_sys_in = ~clk_sys_in;

    register_reset_initializer #(.HAS_BROWN_OUT(1'b1)) i_dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .brown_out_in(ev[4]),
        .external_clear_reset_in(ev[3]), .watchdog_reset_in(ev[2]),
        .wake_watchdog_in(ev[1]), .wake_interrupt_in(ev[0]), .wake_int_flags_in(wflags),
        .sleeping_in(sleeping), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .pc_low_out(pc_low_out), .flags_out(flags_out),
        .global_interrupt_enable_out(global_interrupt_enable));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk_sys_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= wr;
        paddr_in   <= {idx, 2'b00};
        pwdata_in  <= {24'h0, wd};
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (pready_out !== 1'b1) begin
            failures++;
            report_and_stop();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    // pulse a cause for one cycle; outputs are settled on return
    task automatic ev_pulse(input logic [4:0] v, input logic [7:0] f);
        @(posedge clk_sys_in);
        ev     <= v;
        wflags <= f;
        @(posedge clk_sys_in);
        ev     <= 5'h00;
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        foreach (rows[i]) begin
            rdchk(rows[i].idx, rows[i].por);
            chk({31'h0, err}, 32'h0);
            apb(1'b1, rows[i].idx, 8'hff);
            rdchk(rows[i].idx, rows[i].wr);
        end
        ev_pulse(5'b01000, 8'h00);
        foreach (rows[i]) rdchk(rows[i].idx, rows[i].clr);
        rdchk(IDX_CAUSE, 8'h04);
        ev_pulse(5'b00010, 8'h00);
        chk({24'h0, pc_low_out}, 32'h01);
        chk({24'h0, flags_out}, 32'h07);
        rdchk(IDX_INT_CTRL, 8'h01);
        rdchk(IDX_OPTIONS, 8'hff);
        ev_pulse(5'b00001, 8'h04);
        chk({24'h0, pc_low_out}, 32'h02);
        chk({24'h0, flags_out}, 32'h17);
        rdchk(IDX_INT_CTRL, 8'h05);
        apb(1'b1, IDX_INT_CTRL, 8'h80);
        ev_pulse(5'b00001, 8'h02);
        chk({24'h0, pc_low_out}, 32'h04);
        chk({31'h0, global_interrupt_enable}, 32'h1);
        rdchk(IDX_INT_CTRL, 8'h82);
        ev_pulse(5'b00100, 8'h00);
        chk({24'h0, pc_low_out}, 32'h00);
        chk({24'h0, flags_out}, 32'h0f);
        chk({31'h0, global_interrupt_enable}, 32'h0);
        rdchk(IDX_INT_CTRL, 8'h00);
        rdchk(IDX_CAUSE, 8'h08);
        @(posedge clk_sys_in);
        sleeping <= 1'b1;
        ev_pulse(5'b01000, 8'h00);
        chk({24'h0, flags_out}, 32'h17);
        @(posedge clk_sys_in);
        sleeping <= 1'b0;
        apb(1'b1, IDX_OPTIONS, 8'h00);
        ev_pulse(5'b10000, 8'h00);
        chk({24'h0, flags_out}, 32'h18);
        rdchk(IDX_PORT_A, 8'h00);
        rdchk(IDX_OPTIONS, 8'hff);
        rdchk(IDX_PWR_FLAGS, 8'h01);
        apb(1'b0, 8'h07, 8'h00);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h00, 8'h55);
        chk({31'h0, err}, 32'h1);
        @(posedge clk_sys_in);
        srst_in <= 1'b1;
        @(posedge clk_sys_in);
        srst_in <= 1'b0;
        rdchk(IDX_PWR_FLAGS, 8'h00);
        chk({24'h0, flags_out}, 32'h18);
        report_and_stop();
    end
endmodule
`default_nettype wire
